// *** hw/cbao_pkg.sv ***
// Package for the complement and BCD adjust execution block.
// Assumes one synchronous core clock and an operation code from the decoder.
package cbao_pkg;

  // ****************************************
  // Operation codes
  // ****************************************
  typedef enum logic [1:0] {
    CBAO_OP_NONE = 2'b00,
    CBAO_OP_INVERT_IN_PLACE = 2'b01,
    CBAO_OP_INVERT_TO_WORK = 2'b10,
    CBAO_OP_BCD_ADJUST_OP = 2'b11
  } cbao_op_t;

  // ****************************************
  // Data widths and BCD constants
  // ****************************************
  localparam int CBAO_DATA_W = 8;
  localparam int CBAO_NIB_W = 4;
  localparam logic [3:0] CBAO_NIB_MAX = 4'h9;
  localparam logic [3:0] CBAO_NIB_CORR = 4'h6;
  localparam logic [7:0] CBAO_ZERO_BYTE = 8'h00;
  localparam logic [7:0] CBAO_ALL_ONES = 8'hFF;

endpackage : cbao_pkg

// *** hw/cbao_nib_check.sv ***
// Decides whether one BCD nibble needs the decimal correction.
// Purely combinational; the caller registers the result.
module cbao_nib_check #(
  parameter int NIB_W = 4
) (
  // Nibble and its carry-type flag
  input wire logic [NIB_W-1:0] i_nibble,
  input wire logic i_flag,
  // Correction request
  output logic o_need
);

  always_comb begin
    o_need = (i_nibble > NIB_W'(cbao_pkg::CBAO_NIB_MAX)) || i_flag;
  end

endmodule : cbao_nib_check

// *** hw/cbao_core.sv ***
// Execution logic for in-place invert, invert to the working register and BCD adjust.
// Assumes the decoder presents one operation per valid cycle together with the operand
// byte already read from data memory, the working register and the current flags.
// Results come back one clock later as single-cycle write strobes with data.

// Contract
// - In-place invert writes the inverted memory byte back to memory and updates the nil flag.
// - Invert to work puts the inverted memory byte in the working register, memory untouched.
// - BCD adjust adds 6 to the low nibble when it exceeds 9 or the half-nibble flag is set.
// - BCD adjust adds 6 to the high nibble when it exceeds 9 or the wraparound flag is set.
// - The correction is one 8-bit addition of 00H, 06H, 60H or 66H to the working value.
// - BCD adjust reads the working register and writes the result only to data memory.
// - BCD adjust touches no flag but the wraparound flag, which marks a decimal sum of 100 or more.
module cbao_core #(
  parameter int DATA_W = cbao_pkg::CBAO_DATA_W
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // Operation request from the decoder
  input wire logic i_op_valid,
  input wire cbao_pkg::cbao_op_t i_op_code,
  // Operands
  input wire logic [DATA_W-1:0] i_mem_data,
  input wire logic [DATA_W-1:0] i_work_register,
  input wire logic i_half_nibble_flag,
  input wire logic i_wrap_flag,
  // Data memory write-back
  output logic o_mem_wr,
  output logic [DATA_W-1:0] o_mem_wdata,
  // Working register write-back
  output logic o_work_wr,
  output logic [DATA_W-1:0] o_work_wdata,
  // Flag updates
  output logic o_nil_flag_wr,
  output logic o_nil_flag,
  output logic o_wrap_flag_wr,
  output logic o_wrap_flag
);

  localparam int NIB_W = cbao_pkg::CBAO_NIB_W;

  // ****************************************
  // Nibble tests
  // ****************************************
  logic low_need;
  logic high_need;

  cbao_nib_check #(
    .NIB_W(NIB_W)
  ) u_low_check (
    .i_nibble(i_work_register[NIB_W-1:0]),
    .i_flag(i_half_nibble_flag),
    .o_need(low_need)
  );

  cbao_nib_check #(
    .NIB_W(NIB_W)
  ) u_high_check (
    .i_nibble(i_work_register[DATA_W-1:DATA_W-NIB_W]),
    .i_flag(i_wrap_flag),
    .o_need(high_need)
  );

  // ****************************************
  // Datapath
  // ****************************************
  logic [DATA_W-1:0] inverted;
  logic [DATA_W-1:0] bcd_corr;
  logic [DATA_W:0] bcd_sum;

  always_comb begin
    inverted = ~i_mem_data;
    // Single 8-bit add; low nibble carry ripples into the high nibble naturally
    bcd_corr = {(high_need ? cbao_pkg::CBAO_NIB_CORR : 4'h0),
                (low_need ? cbao_pkg::CBAO_NIB_CORR : 4'h0)};
    bcd_sum = {1'b0, i_work_register} + {1'b0, bcd_corr};
  end

  // ****************************************
  // Next-state logic
  // ****************************************
  logic next_mem_wr;
  logic [DATA_W-1:0] next_mem_wdata;
  logic next_work_wr;
  logic [DATA_W-1:0] next_work_wdata;
  logic next_nil_flag_wr;
  logic next_nil_flag;
  logic next_wrap_flag_wr;
  logic next_wrap_flag;

  always_comb begin
    next_mem_wr = 1'b0;
    next_mem_wdata = o_mem_wdata;
    next_work_wr = 1'b0;
    next_work_wdata = o_work_wdata;
    next_nil_flag_wr = 1'b0;
    next_nil_flag = o_nil_flag;
    next_wrap_flag_wr = 1'b0;
    next_wrap_flag = o_wrap_flag;
    if (i_op_valid) begin
      case (i_op_code)
        cbao_pkg::CBAO_OP_INVERT_IN_PLACE: begin
          next_mem_wr = 1'b1;
          next_mem_wdata = inverted;
          next_nil_flag_wr = 1'b1;
          next_nil_flag = (inverted == cbao_pkg::CBAO_ZERO_BYTE);
        end
        cbao_pkg::CBAO_OP_INVERT_TO_WORK: begin
          next_work_wr = 1'b1;
          next_work_wdata = inverted;
          next_nil_flag_wr = 1'b1;
          next_nil_flag = (inverted == cbao_pkg::CBAO_ZERO_BYTE);
        end
        cbao_pkg::CBAO_OP_BCD_ADJUST_OP: begin
          // Result goes to memory only; working register is left alone
          next_mem_wr = 1'b1;
          next_mem_wdata = bcd_sum[DATA_W-1:0];
          // Sticky OR keeps a carry from the preceding add for chained bytes
          next_wrap_flag_wr = 1'b1;
          next_wrap_flag = bcd_sum[DATA_W] | i_wrap_flag;
        end
        default: begin
          next_mem_wr = 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_mem_wr <= 1'b0;
      o_mem_wdata <= cbao_pkg::CBAO_ZERO_BYTE;
      o_work_wr <= 1'b0;
      o_work_wdata <= cbao_pkg::CBAO_ZERO_BYTE;
      o_nil_flag_wr <= 1'b0;
      o_nil_flag <= 1'b0;
      o_wrap_flag_wr <= 1'b0;
      o_wrap_flag <= 1'b0;
    end else begin
      o_mem_wr <= next_mem_wr;
      o_mem_wdata <= next_mem_wdata;
      o_work_wr <= next_work_wr;
      o_work_wdata <= next_work_wdata;
      o_nil_flag_wr <= next_nil_flag_wr;
      o_nil_flag <= next_nil_flag;
      o_wrap_flag_wr <= next_wrap_flag_wr;
      o_wrap_flag <= next_wrap_flag;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb_sys @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_b);

  sequence s_inv_mem;
    i_op_valid && (i_op_code == cbao_pkg::CBAO_OP_INVERT_IN_PLACE);
  endsequence

  sequence s_inv_work;
    i_op_valid && (i_op_code == cbao_pkg::CBAO_OP_INVERT_TO_WORK);
  endsequence

  sequence s_bcd;
    i_op_valid && (i_op_code == cbao_pkg::CBAO_OP_BCD_ADJUST_OP);
  endsequence

  sequence s_quiet;
    !o_mem_wr && !o_work_wr && !o_nil_flag_wr && !o_wrap_flag_wr;
  endsequence

  property p_inv_mem;
    s_inv_mem |=> o_mem_wr && !o_work_wr && (o_mem_wdata == ~$past(i_mem_data))
      && o_nil_flag_wr && (o_nil_flag == ($past(i_mem_data) == cbao_pkg::CBAO_ALL_ONES));
  endproperty
  a_inv_mem: assert property (p_inv_mem) else $error("in-place invert wrong");

  property p_inv_work;
    s_inv_work |=> o_work_wr && !o_mem_wr && (o_work_wdata == ~$past(i_mem_data))
      && o_nil_flag_wr && (o_nil_flag == (o_work_wdata == cbao_pkg::CBAO_ZERO_BYTE));
  endproperty
  a_inv_work: assert property (p_inv_work) else $error("invert to work wrong");

  property p_low_add;
    s_bcd ##0 ((i_work_register[3:0] > 4'h9) || i_half_nibble_flag)
      |=> o_mem_wdata[3:0] == 4'($past(i_work_register[3:0]) + 4'h6);
  endproperty
  a_low_add: assert property (p_low_add) else $error("low nibble not corrected");

  property p_low_keep;
    s_bcd ##0 ((i_work_register[3:0] <= 4'h9) && !i_half_nibble_flag)
      |=> o_mem_wdata[3:0] == $past(i_work_register[3:0]);
  endproperty
  a_low_keep: assert property (p_low_keep) else $error("low nibble altered");

  property p_high_add;
    s_bcd ##0 ((i_work_register[7:4] > 4'h9) || i_wrap_flag)
      |=> (8'(o_mem_wdata - $past(i_work_register)) & 8'hF0) == 8'h60;
  endproperty
  a_high_add: assert property (p_high_add) else $error("high nibble not corrected");

  property p_corr_set;
    s_bcd |=> 8'(o_mem_wdata - $past(i_work_register)) inside {8'h00, 8'h06, 8'h60, 8'h66};
  endproperty
  a_corr_set: assert property (p_corr_set) else $error("illegal correction");

  property p_bcd_dest;
    s_bcd |=> o_mem_wr && !o_work_wr && $stable(o_work_wdata);
  endproperty
  a_bcd_dest: assert property (p_bcd_dest) else $error("bcd result misrouted");

  property p_bcd_flags;
    s_bcd |=> !o_nil_flag_wr && o_wrap_flag_wr && $stable(o_nil_flag);
  endproperty
  a_bcd_flags: assert property (p_bcd_flags) else $error("bcd touched other flag");

  property p_wrap_keep;
    s_bcd ##0 i_wrap_flag |=> o_wrap_flag;
  endproperty
  a_wrap_keep: assert property (p_wrap_keep) else $error("wraparound cleared");

  property p_wrap_set;
    s_bcd |=> o_wrap_flag == ($past(i_wrap_flag)
      || (o_mem_wdata < $past(i_work_register)));
  endproperty
  a_wrap_set: assert property (p_wrap_set) else $error("wraparound wrong");

  property p_idle;
    !i_op_valid |=> s_quiet;
  endproperty
  a_idle: assert property (p_idle) else $error("strobe without request");

endmodule : cbao_core

// *** verification/tb_top.sv ***
// Self-checking bench for the invert and BCD adjust execution block.
// Assumes the block answers at the taking edge itself with one-cycle strobes.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************
  // Signals and instance
  // ****************************************
  logic i_clk_sys, i_rst_b, i_op_valid, i_half_nibble_flag, i_wrap_flag;
  cbao_pkg::cbao_op_t i_op_code;
  logic [7:0] i_mem_data, i_work_register, o_mem_wdata, o_work_wdata;
  logic o_mem_wr, o_work_wr, o_nil_flag_wr, o_nil_flag, o_wrap_flag_wr, o_wrap_flag;
  int n_mismatch = 0;
  int n_checks = 0;
  int n_cycles = 0;

  cbao_core dut (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_op_valid(i_op_valid),
    .i_op_code(i_op_code), .i_mem_data(i_mem_data), .i_work_register(i_work_register),
    .i_half_nibble_flag(i_half_nibble_flag), .i_wrap_flag(i_wrap_flag),
    .o_mem_wr(o_mem_wr), .o_mem_wdata(o_mem_wdata), .o_work_wr(o_work_wr),
    .o_work_wdata(o_work_wdata), .o_nil_flag_wr(o_nil_flag_wr), .o_nil_flag(o_nil_flag),
    .o_wrap_flag_wr(o_wrap_flag_wr), .o_wrap_flag(o_wrap_flag));

  // ****************************************
  // Shared tasks
  // ****************************************
  task final_report;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  task chk_bit(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask : chk_bit

  task chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s %h", $time, what, got);
    end
  endtask : chk_byte

  task chk_strobes(input logic mw, input logic ww, input logic nw, input logic cw);
    chk_bit(o_mem_wr, mw, "mem strobe");
    chk_bit(o_work_wr, ww, "work strobe");
    chk_bit(o_nil_flag_wr, nw, "nil strobe");
    chk_bit(o_wrap_flag_wr, cw, "wrap strobe");
  endtask : chk_strobes

  // Drives one request at a rising edge; the next edge takes it
  task drive(input cbao_pkg::cbao_op_t op, input logic [7:0] mem, input logic [7:0] work,
             input logic hn, input logic wrap);
    i_op_valid <= 1'b1;
    i_op_code <= op;
    i_mem_data <= mem;
    i_work_register <= work;
    i_half_nibble_flag <= hn;
    i_wrap_flag <= wrap;
  endtask : drive

  // Answer registers on the taking edge itself; look just after it
  task take;
    @(posedge i_clk_sys);
    i_op_valid <= 1'b0;
    #1;
  endtask : take

  // ****************************************
  // Scenarios
  // ****************************************
  task t_invert_in_place(input logic [7:0] mem);
    @(posedge i_clk_sys);
    drive(cbao_pkg::CBAO_OP_INVERT_IN_PLACE, mem, 8'h5A, 1'b1, 1'b1);
    take();
    chk_strobes(1'b1, 1'b0, 1'b1, 1'b0);
    chk_byte(o_mem_wdata, ~mem, "in place data");
    chk_bit(o_nil_flag, (mem == 8'hFF), "in place nil");
    @(posedge i_clk_sys);
    #1;
    chk_strobes(1'b0, 1'b0, 1'b0, 1'b0);
    chk_byte(o_mem_wdata, ~mem, "in place hold");
  endtask : t_invert_in_place

  task t_invert_to_work(input logic [7:0] mem);
    @(posedge i_clk_sys);
    drive(cbao_pkg::CBAO_OP_INVERT_TO_WORK, mem, 8'h33, 1'b0, 1'b0);
    take();
    chk_strobes(1'b0, 1'b1, 1'b1, 1'b0);
    chk_byte(o_work_wdata, ~mem, "to work data");
    chk_bit(o_nil_flag, (mem == 8'hFF), "to work nil");
  endtask : t_invert_to_work

  // Expected value worked out nibble by nibble, avoiding high nibble 9 with low carry
  task t_bcd(input logic [7:0] work, input logic hn, input logic wrap);
    logic [8:0] sum;
    sum = {1'b0, work};
    if (work[3:0] > 4'h9 || hn) sum = sum + 9'h006;
    if (work[7:4] > 4'h9 || wrap) sum = sum + 9'h060;
    @(posedge i_clk_sys);
    drive(cbao_pkg::CBAO_OP_BCD_ADJUST_OP, ~work, work, hn, wrap);
    take();
    chk_strobes(1'b1, 1'b0, 1'b0, 1'b1);
    chk_byte(o_mem_wdata, sum[7:0], "bcd result");
    chk_bit(o_wrap_flag, sum[8] | wrap, "bcd wrap");
  endtask : t_bcd

  // No strobe for a dropped valid following a code of none
  task t_refused;
    @(posedge i_clk_sys);
    drive(cbao_pkg::CBAO_OP_NONE, 8'h00, 8'h00, 1'b0, 1'b0);
    @(posedge i_clk_sys);
    i_op_valid <= 1'b0;
    i_op_code <= cbao_pkg::CBAO_OP_INVERT_IN_PLACE;
    repeat (2) begin
      @(posedge i_clk_sys);
      #1;
      chk_strobes(1'b0, 1'b0, 1'b0, 1'b0);
    end
  endtask : t_refused

  // Two requests on consecutive edges
  task t_back_to_back;
    @(posedge i_clk_sys);
    drive(cbao_pkg::CBAO_OP_INVERT_TO_WORK, 8'hC3, 8'h27, 1'b1, 1'b0);
    @(posedge i_clk_sys);
    drive(cbao_pkg::CBAO_OP_BCD_ADJUST_OP, 8'h00, 8'h27, 1'b1, 1'b0);
    #1;
    chk_byte(o_work_wdata, 8'h3C, "first of pair");
    chk_strobes(1'b0, 1'b1, 1'b1, 1'b0);
    take();
    chk_strobes(1'b1, 1'b0, 1'b0, 1'b1);
    chk_byte(o_mem_wdata, 8'h2D, "second of pair");
    chk_byte(o_work_wdata, 8'h3C, "work held");
  endtask : t_back_to_back

  // ****************************************
  // Clock, timeout and main sequence
  // ****************************************
  initial begin
    i_clk_sys = 1'b0;
    forever #25 i_clk_sys = ~i_clk_sys;
  end

  // Ceiling well above the few dozen cycles the sequence needs
  always @(posedge i_clk_sys) begin
    n_cycles++;
    if (n_cycles == 1000) begin
      n_mismatch++;
      final_report();
    end
  end

  initial begin
    i_rst_b = 1'b0;
    i_op_valid <= 1'b0;
    i_op_code <= cbao_pkg::CBAO_OP_NONE;
    i_mem_data <= 8'h00;
    i_work_register <= 8'h00;
    i_half_nibble_flag <= 1'b0;
    i_wrap_flag <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    #1;
    chk_strobes(1'b0, 1'b0, 1'b0, 1'b0);
    chk_byte(o_mem_wdata, 8'h00, "reset data");
    @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    t_invert_in_place(8'hFF);
    t_invert_in_place(8'h81);
    t_invert_to_work(8'h0F);
    t_invert_to_work(8'hFF);
    t_bcd(8'h12, 1'b0, 1'b0);
    t_bcd(8'h1A, 1'b0, 1'b0);
    t_bcd(8'h12, 1'b1, 1'b0);
    t_bcd(8'hA2, 1'b0, 1'b0);
    t_bcd(8'h12, 1'b0, 1'b1);
    t_bcd(8'hBC, 1'b0, 1'b0);
    t_bcd(8'h8A, 1'b0, 1'b0);
    t_bcd(8'h99, 1'b0, 1'b0);
    t_refused();
    t_back_to_back();
    final_report();
  end
endmodule : tb_top
